// ==== src/fsc_filter_setup_config.sv ====
// Filter setup register bank with settling and repeat sequencing
`timescale 1ns/1ps
`default_nettype none
module fsc_filter_setup_config
    import fsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Channel sequencer
    input wire logic seq_start,
    input wire logic [3:0] seq_chan,
    input wire logic [2:0] seq_setup,
    output logic seq_ready,
    output logic chan_done,
    // Operating modes
    input wire logic duty_cycle_en,
    input wire logic calib_en,
    // Filter control
    input wire logic conv_done,
    input wire logic mod_valid,
    output logic conv_start,
    output logic sample_accept,
    output logic settling,
    output logic [2:0] active_setup,
    output logic [3:0] active_filter_mode,
    output logic active_mode_valid,
    output logic sixty_hz_notch,
    output logic avg_enable,
    output logic sinc3_sel,
    output logic [2:0] post_filter,
    output logic [10:0] rate_select
);
    typedef struct packed {
        logic [NUM_SETUPS-1:0][23:0] setup;
        logic wait_n;
        logic [31:0] rdata;
        fsc_state_t state;
        logic [3:0] last_chan;
        logic have_chan;
        logic [2:0] setup_idx;
        logic [4:0] reps;
        logic conv_start;
        logic chan_done;
        logic settling;
        logic sample_accept;
        logic ready;
        logic [3:0] mode;
        logic mode_valid;
        logic notch;
        logic avg;
        logic sinc3;
        logic [2:0] post;
        logic [10:0] rate;
    } fsc_regs_t;

    fsc_regs_t s_r;
    fsc_regs_t s_nxt;

    logic timer_load;
    logic timer_busy;
    logic timer_done;
    logic [23:0] cfg;

    // Settling counter
    fsc_settle_timer u_settle (
        .clock(clock),
        .rst(rst),
        .load(timer_load),
        .code(cfg[SETTLE_LSB +: 3]),
        .busy(timer_busy),
        .done(timer_done)
    );

    // Bus decode helpers
    logic [7:0] word_idx;
    logic setup_hit;
    logic [2:0] setup_sel;
    logic bus_req;
    logic no_repeat;

    assign word_idx = avs_address[9:2];
    assign setup_hit = (word_idx >= IDX_SETUP_FIRST) && (word_idx <= IDX_SETUP_LAST);
    assign setup_sel = 3'(word_idx - IDX_SETUP_FIRST);
    assign bus_req = avs_read || avs_write;
    assign no_repeat = duty_cycle_en || calib_en;
    assign cfg = s_r.setup[seq_setup];

    // Next-state logic for bus slave and sequencer
    always_comb begin
        s_nxt = s_r;
        timer_load = 1'b0;
        s_nxt.conv_start = 1'b0;
        s_nxt.chan_done = 1'b0;
        // One wait cycle, then the answer for one cycle
        s_nxt.wait_n = !(bus_req && s_r.wait_n);
        if (avs_read && s_r.wait_n) begin
            s_nxt.rdata = 32'h00000000;
            if (setup_hit) begin
                s_nxt.rdata[23:0] = s_r.setup[setup_sel] & SETUP_WMASK;
            end else if (word_idx == IDX_STATUS) begin
                s_nxt.rdata[ST_STATE_LSB +: 2] = s_r.state;
                s_nxt.rdata[ST_SETTLE_BIT] = s_r.settling;
                s_nxt.rdata[ST_SETUP_LSB +: 3] = s_r.setup_idx;
                s_nxt.rdata[ST_CHAN_LSB +: 4] = s_r.last_chan;
                s_nxt.rdata[ST_REPS_LSB +: 5] = s_r.reps;
            end
        end
        // Write takes effect at the edge where waitrequest is low
        if (avs_write && !s_r.wait_n && setup_hit) begin
            for (int b = 0; b < 3; b++) begin
                if (avs_byteenable[b]) begin
                    s_nxt.setup[setup_sel][8*b +: 8] = avs_writedata[8*b +: 8];
                end
            end
            s_nxt.setup[setup_sel] = s_nxt.setup[setup_sel] & SETUP_WMASK;
        end
        // Sequencer
        unique case (s_r.state)
            ST_IDLE: begin
                if (seq_start) begin
                    s_nxt.setup_idx = seq_setup;
                    s_nxt.mode = cfg[MODE_LSB +: 4];
                    s_nxt.mode_valid = (cfg[MODE_LSB +: 4] <= MODE_SINC3_PF4);
                    s_nxt.notch = (cfg[MODE_LSB +: 4] == MODE_SINC3_N60);
                    s_nxt.avg = (cfg[MODE_LSB +: 4] == MODE_SINC4_AVG) || (cfg[MODE_LSB +: 4] == MODE_SINC3_AVG);
                    s_nxt.sinc3 = (cfg[MODE_LSB +: 4] >= MODE_SINC3) && (cfg[MODE_LSB +: 4] <= MODE_SINC3_PF4);
                    s_nxt.post = 3'h0;
                    if ((cfg[MODE_LSB +: 4] >= MODE_SINC3_PF1) && (cfg[MODE_LSB +: 4] <= MODE_SINC3_PF4)) begin
                        s_nxt.post = 3'(cfg[MODE_LSB +: 4] - MODE_SINC3_PF1) + 3'h1;
                    end
                    // Zero rate select behaves as one
                    s_nxt.rate = (cfg[RATE_LSB +: 11] == 11'h000) ? RATE_MIN : cfg[RATE_LSB +: 11];
                    s_nxt.reps = no_repeat ? 5'h00 : cfg[REPEAT_LSB +: 5];
                    s_nxt.last_chan = seq_chan;
                    s_nxt.have_chan = 1'b1;
                    s_nxt.ready = 1'b0;
                    if (!s_r.have_chan || seq_chan != s_r.last_chan) begin
                        timer_load = 1'b1;
                        s_nxt.settling = 1'b1;
                        s_nxt.state = ST_SETTLE;
                    end else begin
                        s_nxt.conv_start = 1'b1;
                        s_nxt.state = ST_CONV;
                    end
                end
            end
            ST_SETTLE: begin
                if (timer_done) begin
                    s_nxt.settling = 1'b0;
                    s_nxt.conv_start = 1'b1;
                    s_nxt.state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    if (s_r.reps != 5'h00 && !no_repeat) begin
                        s_nxt.reps = s_r.reps - 5'h01;
                        s_nxt.conv_start = 1'b1;
                    end else begin
                        s_nxt.reps = 5'h00;
                        s_nxt.chan_done = 1'b1;
                        s_nxt.ready = 1'b1;
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase
        // Modulator samples only while converting
        s_nxt.sample_accept = (s_r.state == ST_CONV) && mod_valid;
    end

    // State register with defined reset values
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
            s_r.setup <= {NUM_SETUPS{SETUP_RESET}};
            s_r.wait_n <= 1'b1;
            s_r.state <= ST_IDLE;
            s_r.ready <= 1'b1;
            s_r.mode <= SETUP_RESET[MODE_LSB +: 4];
            s_r.mode_valid <= 1'b1;
            s_r.sinc3 <= 1'b1;
            s_r.rate <= SETUP_RESET[RATE_LSB +: 11];
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata = s_r.rdata;
    assign avs_waitrequest = s_r.wait_n;
    assign seq_ready = s_r.ready;
    assign chan_done = s_r.chan_done;
    assign conv_start = s_r.conv_start;
    assign sample_accept = s_r.sample_accept;
    assign settling = s_r.settling;
    assign active_setup = s_r.setup_idx;
    assign active_filter_mode = s_r.mode;
    assign active_mode_valid = s_r.mode_valid;
    assign sixty_hz_notch = s_r.notch;
    assign avg_enable = s_r.avg;
    assign sinc3_sel = s_r.sinc3;
    assign post_filter = s_r.post;
    assign rate_select = s_r.rate;

    // Bus handshake checks
    a_wait_drops: assert property (@(posedge clock) disable iff (rst)
        (bus_req && avs_waitrequest) |=> !avs_waitrequest) else $error("waitrequest did not drop");
    a_wait_rises: assert property (@(posedge clock) disable iff (rst)
        !avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low for more than one cycle");
    a_read_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
        (avs_read && avs_waitrequest && setup_hit) |=> avs_readdata[31:24] == 8'h00 && !avs_readdata[RSVD_BIT])
        else $error("reserved read bits not zero");

    // Register content checks
    a_reset_value: assert property (@(posedge clock)
        rst |=> s_r.setup[0] == SETUP_RESET && s_r.setup[7] == SETUP_RESET)
        else $error("setup reset value wrong");
    a_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
        avs_write && !avs_waitrequest && setup_hit |=> s_r.setup[$past(setup_sel)][RSVD_BIT] == 1'b0)
        else $error("reserved bit stored");

    // Sequencer checks
    a_switch_settles: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == ST_IDLE && seq_start && s_r.have_chan && seq_chan != s_r.last_chan)
        |=> settling && !conv_start) else $error("no settling after channel change");
    a_first_settles: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == ST_IDLE && seq_start && !s_r.have_chan) |=> settling && !conv_start)
        else $error("no settling on first channel");
    a_repeat_direct: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == ST_CONV && conv_done && s_r.reps != 5'h00 && !no_repeat) |=> conv_start && !settling)
        else $error("repeat conversion delayed");
    a_no_repeat: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == ST_IDLE && seq_start && no_repeat) |=> s_r.reps == 5'h00)
        else $error("repeat used in duty or calibration mode");
    a_settle_gate: assert property (@(posedge clock) disable iff (rst)
        settling |-> !sample_accept && !conv_start) else $error("sample taken while settling");
    a_settle_busy: assert property (@(posedge clock) disable iff (rst)
        (settling && !timer_done) |-> timer_busy) else $error("settling without a running counter");
    a_done_idle: assert property (@(posedge clock) disable iff (rst)
        chan_done |-> seq_ready && !conv_start) else $error("channel done while still converting");
    a_rate_nonzero: assert property (@(posedge clock) disable iff (rst)
        rate_select != 11'h000) else $error("rate select zero");
    a_notch_mode: assert property (@(posedge clock) disable iff (rst)
        sixty_hz_notch |-> active_filter_mode == MODE_SINC3_N60 && sinc3_sel)
        else $error("notch with wrong mode");
    a_mode_follows: assert property (@(posedge clock) disable iff (rst)
        (s_r.state == ST_IDLE && seq_start) |=> active_filter_mode == $past(cfg[MODE_LSB +: 4]))
        else $error("filter mode not from selected setup");
endmodule
`default_nettype wire

// ==== src/fsc_pkg.sv ====
// Constants and types shared by the filter setup register bank
// What this block does
// - Eight 24-bit setup registers sit at consecutive indices 0x21 to 0x28, each reset to 0x002030.
// - A channel is converted with the filter settings of the setup that its setup-select names.
// - A three-bit settle field in bits 23:21 delays the start of conversion on a channel.
// - The settle delay is 32 master-clock cycles shifted left by the field value, 32 to 4096 cycles.
// - The settle delay is inserted each time the sequencer moves to a different channel.
// - No settle delay is inserted before the repeated conversions on the same channel.
// - A five-bit repeat field N in bits 20:16 makes the channel convert N plus one times.
// - The repeat field is ignored while duty cycling or any calibration is active.
// - A four-bit filter-mode field in bits 15:12 resets to two, and code 0000 is plain sinc4.
// - Filter-mode code 0001 is sinc4 followed by sinc1 averaging.
// - Codes 0010 to 1000 are sinc3 plain, with a 60 Hz notch, with averaging, and four post filters.
// - An eleven-bit rate select in bits 10:0 resets to 0x30, and zero acts as one.
package fsc_pkg;
    localparam int NUM_SETUPS = 8;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SETUP_FIRST = 8'h21;
    localparam logic [7:0] IDX_SETUP_LAST = 8'h28;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    // Setup register layout
    localparam logic [23:0] SETUP_RESET = 24'h002030;
    localparam logic [23:0] SETUP_WMASK = 24'hFFF7FF;
    localparam int SETTLE_LSB = 21;
    localparam int REPEAT_LSB = 16;
    localparam int MODE_LSB = 12;
    localparam int RSVD_BIT = 11;
    localparam int RATE_LSB = 0;
    // Status register layout
    localparam int ST_STATE_LSB = 0;
    localparam int ST_SETTLE_BIT = 2;
    localparam int ST_SETUP_LSB = 3;
    localparam int ST_CHAN_LSB = 6;
    localparam int ST_REPS_LSB = 10;
    // Settling base count in master-clock cycles
    localparam logic [12:0] SETTLE_BASE_CYC = 13'h0020;
    // Rate select substitute for a zero code
    localparam logic [10:0] RATE_MIN = 11'h001;
    // Filter-mode codes
    localparam logic [3:0] MODE_SINC4 = 4'h0;
    localparam logic [3:0] MODE_SINC4_AVG = 4'h1;
    localparam logic [3:0] MODE_SINC3 = 4'h2;
    localparam logic [3:0] MODE_SINC3_N60 = 4'h3;
    localparam logic [3:0] MODE_SINC3_AVG = 4'h4;
    localparam logic [3:0] MODE_SINC3_PF1 = 4'h5;
    localparam logic [3:0] MODE_SINC3_PF4 = 4'h8;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} fsc_state_t;
endpackage

// ==== src/fsc_settle_timer.sv ====
// Front-end settling down-counter
`timescale 1ns/1ps
`default_nettype none
module fsc_settle_timer
    import fsc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [2:0] code,
    // Status
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [12:0] cnt;
        logic done;
    } fsc_tmr_t;

    fsc_tmr_t s_r;
    fsc_tmr_t s_nxt;

    // Load 32 << code, then count master-clock cycles down to zero
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (load) begin
            s_nxt.cnt = SETTLE_BASE_CYC << code;
        end else if (s_r.cnt != 13'h0000) begin
            s_nxt.cnt = s_r.cnt - 13'h0001;
            s_nxt.done = (s_r.cnt == 13'h0001);
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.cnt != 13'h0000);
    assign done = s_r.done;

    a_load_value: assert property (@(posedge clock) disable iff (rst)
        load |=> s_r.cnt == (SETTLE_BASE_CYC << $past(code))) else $error("settle count loaded wrong");
    a_done_at_end: assert property (@(posedge clock) disable iff (rst)
        done |-> $past(s_r.cnt) == 13'h0001 && !$past(load)) else $error("settle done out of place");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the filter setup register bank and its sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fsc_pkg::*;
    logic clock, rst, avs_read, avs_write, avs_waitrequest, seq_start, seq_ready, chan_done;
    logic duty_cycle_en, calib_en, conv_done, mod_valid, conv_start, sample_accept, settling;
    logic active_mode_valid, sixty_hz_notch, avg_enable, sinc3_sel;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, seq_chan, active_filter_mode;
    logic [2:0] seq_setup, active_setup, post_filter;
    logic [10:0] rate_select;
    int mismatches = 0;
    int samples_checked = 0;

    fsc_filter_setup_config i_fsc_filter_setup_config (.clock(clock), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .seq_start(seq_start), .seq_chan(seq_chan), .seq_setup(seq_setup), .seq_ready(seq_ready),
        .chan_done(chan_done), .duty_cycle_en(duty_cycle_en), .calib_en(calib_en), .conv_done(conv_done),
        .mod_valid(mod_valid), .conv_start(conv_start), .sample_accept(sample_accept), .settling(settling),
        .active_setup(active_setup), .active_filter_mode(active_filter_mode),
        .active_mode_valid(active_mode_valid), .sixty_hz_notch(sixty_hz_notch), .avg_enable(avg_enable),
        .sinc3_sel(sinc3_sel), .post_filter(post_filter), .rate_select(rate_select));

    // Clock generation, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Compare a seen value against the expected one
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) chk("bus_answer", 0, 1);
    endtask

    // Start a channel, time the settle wait and count conversions until chan_done
    task automatic run_chan(input logic [3:0] ch, input logic [2:0] su, input int first, input int convs);
        int k, n, bad;
        logic fin;
        k = 0;
        n = 1;
        bad = 0;
        fin = 1'b0;
        @(posedge clock);
        seq_chan <= ch;
        seq_setup <= su;
        seq_start <= 1'b1;
        @(posedge clock);
        seq_start <= 1'b0;
        chk("ready_at_start", seq_ready, 1);
        do begin
            @(posedge clock);
            k++;
            if (k == 1) chk("settling", settling, first > 1);
            if (conv_start !== 1'b1 && sample_accept !== 1'b0) bad++;
        end while (conv_start !== 1'b1 && k < 5000);
        chk("first_start", k, first);
        chk("no_samples_settling", bad, 0);
        while (!fin) begin
            repeat (2) @(posedge clock);
            chk("sample_accept", sample_accept, 1);
            conv_done <= 1'b1;
            @(posedge clock);
            conv_done <= 1'b0;
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (conv_start !== 1'b1 && chan_done !== 1'b1 && k < 4);
            if (chan_done === 1'b1 || k >= 4) fin = 1'b1;
            else n++;
        end
        chk("conversions", n, convs);
        chk("active_setup", active_setup, su);
    endtask

    // Reset values, bit 11 masking, byte lanes and unmapped addresses
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 10'(32'h84 + 4 * i), 32'h0, rd);
            chk("setup_reset", rd, 32'h00002030);
        end
        bus(1'b1, 10'h0A0, 32'hFFFFFFFF, rd);
        bus(1'b0, 10'h0A0, 32'h0, rd);
        chk("setup7_rw", rd, 32'h00FFF7FF);
        avs_byteenable <= 4'h1;
        bus(1'b1, 10'h090, 32'hFFFFFFFF, rd);
        avs_byteenable <= 4'hF;
        bus(1'b0, 10'h090, 32'h0, rd);
        chk("setup3_lane0", rd, 32'h000020FF);
        bus(1'b1, 10'h3FC, 32'hFFFFFFFF, rd);
        bus(1'b0, 10'h3FC, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
    endtask

    // Settle delays, repeats and their suppression
    task automatic t_seq();
        run_chan(4'h1, 3'h0, 34, 1);
        chk("rate_default", rate_select, 11'h030);
        chk("mode_default", active_filter_mode, 4'h2);
        bus(1'b1, 10'h088, 32'h00621000, rd);
        run_chan(4'h2, 3'h1, 258, 3);
        chk("rate_zero", rate_select, 11'h001);
        chk("avg_sinc4", avg_enable, 1);
        run_chan(4'h2, 3'h1, 1, 3);
        duty_cycle_en <= 1'b1;
        run_chan(4'h2, 3'h1, 1, 1);
        duty_cycle_en <= 1'b0;
        calib_en <= 1'b1;
        // Setup 7 carries the longest settle code, as for an excited input
        run_chan(4'h3, 3'h7, 4098, 1);
        calib_en <= 1'b0;
        chk("reserved_mode", active_mode_valid, 0);
        bus(1'b0, 10'h080, 32'h0, rd);
        chk("status_idle", rd, 32'h000000F8);
    endtask

    // Reset in mid-run restores the setups and forgets the last channel
    task automatic t_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("rate_after_reset", rate_select, 11'h030);
        chk("mode_after_reset", active_filter_mode, 4'h2);
        bus(1'b0, 10'h08C, 32'h0, rd);
        chk("setup_after_reset", rd, 32'h00002030);
        run_chan(4'h3, 3'h2, 34, 1);
    endtask

    // Every filter-mode code and its decoded outputs
    task automatic t_modes();
        for (int m = 0; m < 16; m++) begin
            bus(1'b1, 10'h08C, 32'(m << 12) | 32'h5, rd);
            run_chan(4'h3, 3'h2, 1, 1);
            chk("mode", active_filter_mode, m);
            chk("mode_valid", active_mode_valid, m <= 8);
            chk("notch", sixty_hz_notch, m == 3);
            chk("avg", avg_enable, m == 1 || m == 4);
            chk("sinc3", sinc3_sel, m >= 2 && m <= 8);
            chk("post", post_filter, (m >= 5 && m <= 8) ? m - 4 : 0);
            chk("rate", rate_select, 11'h005);
        end
    endtask

    // Watchdog against a hung handshake
    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, seq_start, duty_cycle_en, calib_en, conv_done} = 6'h00;
        avs_address = 10'h000;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        seq_chan = 4'h0;
        seq_setup = 3'h0;
        mod_valid = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_seq();
        t_modes();
        t_reset();
        close_out();
    end
endmodule
`default_nettype wire
